// ---- hdx_pkg.sv ----
// Shared constants for the host to signal-core exchange port
package hdx_pkg;
    // ------------------------------------------------------------
    // Special-register addresses
    // ------------------------------------------------------------
    localparam logic [15:0] ADDR_DATA_LO = 16'hff60;
    localparam logic [15:0] ADDR_DATA_HI = 16'hff61;
    localparam logic [15:0] ADDR_STAT_A = 16'hff62;
    localparam logic [15:0] ADDR_STAT_B = 16'hff63;
    localparam logic [15:0] ADDR_CTRL = 16'hff64;
    // ------------------------------------------------------------
    // Fields and reset values
    // ------------------------------------------------------------
    localparam int CTRL_RESET_BIT = 0;
    localparam int CTRL_IRQ_BIT = 1;
    localparam logic [1:0] CTRL_RESET_VAL = 2'h0;
    localparam logic [15:0] STAT_RESET_VAL = 16'h0000;
    localparam logic [15:0] STAT_MEANING_MASK = 16'hffe0;
    localparam int STAT_WIDTH_BIT = 10;
    localparam int FIFO_DEPTH = 4;
endpackage

// ---- hdx_word_if.sv ----
// Word channel between the exchange port and its FIFO
`timescale 1ns/1ps
interface hdx_word_if #(parameter int W = 16);
    logic valid;
    logic ready;
    logic [W-1:0] data;
    modport src (output valid, output data, input ready);
    modport dst (input valid, input data, output ready);
endinterface

// ---- hdx_fifo.sv ----
// Small FIFO carrying words toward the signal core
`timescale 1ns/1ps
module hdx_fifo #(
    parameter int W = 16,
    parameter int DEPTH = 4
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Fill side
    hdx_word_if.dst inp,
    // Drain side
    output logic outValid,
    output logic [W-1:0] outData,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    logic [W-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr_q, wrPtr_d, rdPtr_q, rdPtr_d;
    logic [AW:0] count_q, count_d;
    logic push, pop;

    assign inp.ready = (count_q != (AW+1)'(DEPTH));
    assign outValid = (count_q != '0);
    assign outData = mem[rdPtr_q];

    always_comb begin
        push = inp.valid && inp.ready;
        pop = outValid && outReady;
        wrPtr_d = push ? ((wrPtr_q == AW'(DEPTH-1)) ? '0 : wrPtr_q + 1'b1) : wrPtr_q;
        rdPtr_d = pop ? ((rdPtr_q == AW'(DEPTH-1)) ? '0 : rdPtr_q + 1'b1) : rdPtr_q;
        count_d = count_q + (AW+1)'(push) - (AW+1)'(pop);
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            wrPtr_q <= '0;
            rdPtr_q <= '0;
            count_q <= '0;
        end else if (clkEn) begin
            wrPtr_q <= wrPtr_d;
            rdPtr_q <= rdPtr_d;
            count_q <= count_d;
        end
    end

    always_ff @(posedge clk) begin
        if (clkEn && push) begin
            mem[wrPtr_q] <= inp.data;
        end
    end
endmodule

// ---- hdx_port.sv ----
// Host-side exchange port: data, status and core control registers
`timescale 1ns/1ps
// Behaviour
// - Control bit 0 set holds the signal core in reset.
// - Bit 1 rising sends one interrupt to the core, then self-clears.
// - Control register is two bits and resets to zero.
// - Control register decoded at its address on bus bits 1:0.
// - Reading control register returns zero on bits 7 to 2.
// - Status keeps eleven meaningful bits inside a 16-bit register.
// - Either status address reads the status upper byte.
// - Status clears to zero on reset.
// - A 16-bit word moves as low byte first, then high byte.
// - Core side sees the whole 16-bit word in one transfer.
// - In byte mode only the low byte moves; high keeps old value.
// - Host reads and writes data through low and high addresses.
module hdx_port #(
    parameter int DEPTH = hdx_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    input wire logic clkEn,
    // Host special-register bus
    input wire logic [15:0] hostAddr,
    input wire logic hostWr,
    input wire logic hostRd,
    input wire logic [7:0] hostWrData,
    output logic [7:0] hostRdData,
    // Signal core control
    output logic coreReset,
    output logic coreIrq,
    // Signal core status write
    input wire logic statWr,
    input wire logic [15:0] statWrData,
    // Words toward the signal core
    output logic coreRxValid,
    output logic [15:0] coreRxData,
    input wire logic coreRxReady,
    // Word from the signal core
    input wire logic coreTxWr,
    input wire logic [15:0] coreTxData,
    // Host write refused while FIFO is full
    output logic hostWrBusy
);
    // ------------------------------------------------------------
    // Decode
    // ------------------------------------------------------------
    logic selLo, selHi, selStat, selCtrl;
    logic byteMode;
    logic pushWord;
    logic [15:0] pushData;

    assign selCtrl = (hostAddr == hdx_pkg::ADDR_CTRL);
    assign selLo = (hostAddr == hdx_pkg::ADDR_DATA_LO);
    assign selHi = (hostAddr == hdx_pkg::ADDR_DATA_HI);
    assign selStat = (hostAddr == hdx_pkg::ADDR_STAT_A) || (hostAddr == hdx_pkg::ADDR_STAT_B);

    // ------------------------------------------------------------
    // First cycle after reset, for the reset-value checks
    // ------------------------------------------------------------
    logic firstCycle_q, firstCycle_d;

    always_comb begin
        firstCycle_d = 1'b0;
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            firstCycle_q <= 1'b1;
        end else if (clkEn) begin
            firstCycle_q <= firstCycle_d;
        end
    end

    // ------------------------------------------------------------
    // Control register
    // ------------------------------------------------------------
    logic [1:0] ctrl_q, ctrl_d;
    logic irq_q, irq_d;

    always_comb begin
        ctrl_d = ctrl_q;
        irq_d = 1'b0;
        if (hostWr && selCtrl) begin
            ctrl_d = hostWrData[1:0];
            if (hostWrData[hdx_pkg::CTRL_IRQ_BIT] && !ctrl_q[hdx_pkg::CTRL_IRQ_BIT]) begin
                irq_d = 1'b1;
            end
        end
        // The bit lives one cycle so a read may still see it; rearming needs a new write
        if (irq_q) begin
            ctrl_d[hdx_pkg::CTRL_IRQ_BIT] = 1'b0;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            ctrl_q <= hdx_pkg::CTRL_RESET_VAL;
            irq_q <= 1'b0;
        end else if (clkEn) begin
            ctrl_q <= ctrl_d;
            irq_q <= irq_d;
        end
    end

    assign coreReset = ctrl_q[hdx_pkg::CTRL_RESET_BIT];
    assign coreIrq = irq_q;

    chk_ctrl_low_lines: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selCtrl && !coreIrq |=> ctrl_q == $past(hostWrData[1:0]))
        else $error("control write not taken from bus bits 1:0");

    chk_ctrl_other_addr: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !(hostWr && selCtrl) && !coreIrq |=> $stable(ctrl_q))
        else $error("control register changed without its address");

    chk_irq_no_spurious: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !(hostWr && selCtrl && hostWrData[1] && !ctrl_q[1]) |=> !coreIrq)
        else $error("core interrupt without a bit 1 rise");

    chk_irq_bit_set: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selCtrl && hostWrData[1] && !ctrl_q[1] |=> ctrl_q[1])
        else $error("interrupt bit not set by its write");

    chk_ctrl_reset_zero: assert property (@(posedge clk) disable iff (!rst_n)
        firstCycle_q |-> ctrl_q == hdx_pkg::CTRL_RESET_VAL && !coreIrq)
        else $error("control register not zero after reset");

    // ------------------------------------------------------------
    // Status register
    // ------------------------------------------------------------
    logic [15:0] stat_q, stat_d;

    always_comb begin
        stat_d = stat_q;
        if (statWr) begin
            stat_d = statWrData & hdx_pkg::STAT_MEANING_MASK;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            stat_q <= hdx_pkg::STAT_RESET_VAL;
        end else if (clkEn) begin
            stat_q <= stat_d;
        end
    end

    assign byteMode = stat_q[hdx_pkg::STAT_WIDTH_BIT];

    chk_stat_capture: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && statWr |=> stat_q == ($past(statWrData) & hdx_pkg::STAT_MEANING_MASK))
        else $error("status word not stored");

    chk_stat_hold: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && !statWr |=> $stable(stat_q))
        else $error("status changed without a core write");

    chk_stat_reset_zero: assert property (@(posedge clk) disable iff (!rst_n)
        firstCycle_q |-> stat_q == hdx_pkg::STAT_RESET_VAL)
        else $error("status not zero after reset");

    // ------------------------------------------------------------
    // Data register
    // ------------------------------------------------------------
    logic [15:0] data_q, data_d;
    logic [7:0] loHold_q, loHold_d;
    hdx_word_if #(.W(16)) toCore ();

    always_comb begin
        data_d = data_q;
        loHold_d = loHold_q;
        pushWord = 1'b0;
        pushData = data_q;
        if (hostWr && selLo) begin
            if (byteMode) begin
                // low byte only, high byte kept
                pushWord = 1'b1;
                pushData = {data_q[15:8], hostWrData};
                if (toCore.ready) begin
                    data_d = pushData;
                end
            end else begin
                loHold_d = hostWrData;
            end
        end else if (hostWr && selHi && !byteMode) begin
            // whole word goes out at once
            pushWord = 1'b1;
            pushData = {hostWrData, loHold_q};
            if (toCore.ready) begin
                data_d = pushData;
            end
        end
        // Core write lands in one transfer; host write wins a collision
        if (coreTxWr && !pushWord) begin
            data_d = coreTxData;
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            data_q <= 16'h0000;
            loHold_q <= 8'h00;
        end else if (clkEn) begin
            data_q <= data_d;
            loHold_q <= loHold_d;
        end
    end

    assign toCore.valid = pushWord;
    assign toCore.data = pushData;
    // Back-pressure: a write into a full FIFO is dropped, so software polls this first
    assign hostWrBusy = !toCore.ready;

    chk_lo_held: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selLo && !byteMode |-> !toCore.valid)
        else $error("low byte pushed before high byte");

    chk_lo_captured: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selLo && !byteMode |=> loHold_q == $past(hostWrData))
        else $error("low byte not held");

    chk_word_out: assert property (@(posedge clk) disable iff (!rst_n)
        hostWr && selHi && !byteMode |-> toCore.valid && toCore.data == {hostWrData, loHold_q})
        else $error("word not offered whole on high byte write");

    chk_hi_ignored: assert property (@(posedge clk) disable iff (!rst_n)
        hostWr && selHi && byteMode |-> !toCore.valid)
        else $error("high byte write moved data in byte mode");

    chk_drop_keeps: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && toCore.valid && !toCore.ready |=> $stable(data_q))
        else $error("refused word changed the data register");

    chk_core_word: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && coreTxWr && !toCore.valid |=> data_q == $past(coreTxData))
        else $error("core word not loaded in one transfer");

    chk_busy_full: assert property (@(posedge clk) disable iff (!rst_n)
        hostWrBusy |-> coreRxValid)
        else $error("busy while no word is queued");

    hdx_fifo #(.W(16), .DEPTH(DEPTH)) uFifo (
        .clk(clk),
        .rst_n(rst_n),
        .clkEn(clkEn),
        .inp(toCore),
        .outValid(coreRxValid),
        .outData(coreRxData),
        .outReady(coreRxReady)
    );

    // ------------------------------------------------------------
    // Read mux
    // ------------------------------------------------------------
    logic [7:0] rd_q, rd_d;

    always_comb begin
        rd_d = 8'h00;
        if (hostRd) begin
            if (selCtrl) begin
                rd_d = {6'h00, ctrl_q};
            end else if (selStat) begin
                rd_d = stat_q[15:8];
            end else if (selLo) begin
                rd_d = data_q[7:0];
            end else if (selHi) begin
                rd_d = data_q[15:8];
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rd_q <= 8'h00;
        end else if (clkEn) begin
            rd_q <= rd_d;
        end
    end

    assign hostRdData = rd_q;

    chk_read_lo: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostRd && selLo |=> hostRdData == $past(data_q[7:0]))
        else $error("data low read wrong");

    chk_read_hi: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostRd && selHi |=> hostRdData == $past(data_q[15:8]))
        else $error("data high read wrong");

    chk_unmapped_zero: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostRd && !(selCtrl || selStat || selLo || selHi) |=> hostRdData == 8'h00)
        else $error("unmapped read not zero");

    chk_read_reset_zero: assert property (@(posedge clk) disable iff (!rst_n)
        firstCycle_q |-> hostRdData == 8'h00 && data_q == 16'h0000)
        else $error("data or read byte not zero after reset");

    // ------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------
    chk_irq_pulse_once: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && coreIrq |=> !coreIrq)
        else $error("core interrupt longer than one cycle");
    chk_irq_on_rise: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selCtrl && hostWrData[1] && !ctrl_q[1] |=> coreIrq)
        else $error("interrupt missing after bit 1 rise");
    chk_irq_selfclear: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && coreIrq && !(hostWr && selCtrl) |=> !ctrl_q[1])
        else $error("interrupt bit not cleared");
    chk_reset_follows: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selCtrl |=> coreReset == $past(hostWrData[hdx_pkg::CTRL_RESET_BIT]))
        else $error("core reset not following bit 0");
    chk_ctrl_read_zero: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostRd && selCtrl |=> hostRdData[7:2] == 6'h00)
        else $error("control read upper bits not zero");
    chk_stat_read_hi: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostRd && selStat && !statWr |=> hostRdData == stat_q[15:8])
        else $error("status read wrong byte");
    chk_stat_eleven_bits: assert property (@(posedge clk) disable iff (!rst_n)
        stat_q[4:0] == 5'h00)
        else $error("status low bits not zero");
    chk_word_pair: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selHi && !byteMode && toCore.ready |=> data_q[7:0] == $past(loHold_q))
        else $error("word not paired with held low byte");
    chk_byte_keeps_hi: assert property (@(posedge clk) disable iff (!rst_n)
        clkEn && hostWr && selLo && byteMode && !coreTxWr |=> $stable(data_q[15:8]))
        else $error("byte mode disturbed high byte");
endmodule

// ---- hdx_core_model.sv ----
// Signal-core side model: takes words from the port and tallies interrupt pulses
`timescale 1ns/1ps
module hdx_core_model (
    // Clock and reset
    input wire logic clk,
    input wire logic rst_n,
    // Port outputs toward the core
    input wire logic coreReset,
    input wire logic coreIrq,
    input wire logic coreRxValid,
    input wire logic [15:0] coreRxData,
    // Flow control
    input wire logic stall,
    output logic coreRxReady,
    // Tallies
    output int rxCount,
    output int irqCount
);
    logic [15:0] rxLog [0:15];
    // A core held in reset takes nothing, so words wait in the FIFO
    assign coreRxReady = !stall && !coreReset;
    always @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            rxCount <= 0;
            irqCount <= 0;
        end else begin
            if (coreRxValid && coreRxReady) begin
                rxLog[rxCount % 16] <= coreRxData;
                rxCount <= rxCount + 1;
            end
            if (coreIrq) begin
                irqCount <= irqCount + 1;
            end
        end
    end
endmodule

// ---- host_to_dsp_exchange_port_tb.sv ----
// Self-checking bench for the exchange port
`timescale 1ns/1ps
module host_to_dsp_exchange_port_tb;
    logic clk, rst_n, clkEn, hostWr, hostRd, statWr, coreTxWr, stall;
    logic [15:0] hostAddr, statWrData, coreTxData, coreRxData;
    logic [7:0] hostWrData, hostRdData, v;
    logic coreReset, coreIrq, coreRxValid, coreRxReady, hostWrBusy;
    int rxCount, irqCount, n_fail, cmp_count, b;
    hdx_port i_dut (.clk(clk), .rst_n(rst_n), .clkEn(clkEn), .hostAddr(hostAddr), .hostWr(hostWr),
        .hostRd(hostRd), .hostWrData(hostWrData), .hostRdData(hostRdData), .coreReset(coreReset),
        .coreIrq(coreIrq), .statWr(statWr), .statWrData(statWrData), .coreRxValid(coreRxValid),
        .coreRxData(coreRxData), .coreRxReady(coreRxReady), .coreTxWr(coreTxWr), .coreTxData(coreTxData),
        .hostWrBusy(hostWrBusy));
    hdx_core_model i_core (.clk(clk), .rst_n(rst_n), .coreReset(coreReset), .coreIrq(coreIrq),
        .coreRxValid(coreRxValid), .coreRxData(coreRxData), .stall(stall), .coreRxReady(coreRxReady),
        .rxCount(rxCount), .irqCount(irqCount));
    // ------------------------------------------------------------
    // Shared tasks
    // ------------------------------------------------------------
    task automatic chk(input logic [15:0] s, input logic [15:0] e, input string m);
        cmp_count++;
        if (s !== e) begin
            n_fail++;
            $display("wrong value at %0t: %s seen %h expected %h", $time, m, s, e);
        end
    endtask
    // One assignment per falling edge, so back-to-back strobes never collide
    task automatic drv(input logic w, input logic r, input logic [15:0] a, input logic [7:0] d);
        @(negedge clk);
        hostWr = w;
        hostRd = r;
        hostAddr = a;
        hostWrData = d;
    endtask
    task automatic rd(input logic [15:0] a, output logic [7:0] q);
        drv(1'b0, 1'b1, a, 8'h00);
        drv(1'b0, 1'b0, 16'h0000, 8'h00);
        q = hostRdData;
    endtask
    task automatic rdchk(input logic [15:0] a, input logic [7:0] e, input string m);
        rd(a, v);
        chk({8'h00, v}, {8'h00, e}, m);
    endtask
    task automatic stat(input logic [15:0] s);
        @(negedge clk);
        statWr = 1'b1;
        statWrData = s;
        @(negedge clk);
        statWr = 1'b0;
    endtask
    task automatic wr(input logic [15:0] a, input logic [7:0] d);
        drv(1'b1, 1'b0, a, d);
    endtask
    task automatic settle();
        drv(1'b0, 1'b0, 16'h0000, 8'h00);
        repeat (3) @(negedge clk);
    endtask
    // ------------------------------------------------------------
    // Scenarios
    // ------------------------------------------------------------
    task automatic t_reset_vals();
        chk({15'h0000, coreReset}, 16'h0000, "core reset after reset");
        rdchk(hdx_pkg::ADDR_CTRL, 8'h00, "control reset value");
        rdchk(hdx_pkg::ADDR_STAT_A, 8'h00, "status reset value");
    endtask
    task automatic t_ctrl();
        b = irqCount;
        wr(hdx_pkg::ADDR_CTRL, 8'h02);
        settle();
        chk(16'(irqCount - b), 16'h0001, "one irq pulse");
        rdchk(hdx_pkg::ADDR_CTRL, 8'h00, "irq bit self clears");
        wr(hdx_pkg::ADDR_CTRL, 8'hff);
        wr(16'hff66, 8'h00);
        settle();
        chk({15'h0000, coreReset}, 16'h0001, "core held in reset");
        chk(16'(irqCount - b), 16'h0002, "second rise second pulse");
        rdchk(hdx_pkg::ADDR_CTRL, 8'h01, "upper bits read zero");
        rdchk(16'hff65, 8'h00, "unmapped reads zero");
        wr(hdx_pkg::ADDR_CTRL, 8'h00);
        settle();
        chk({15'h0000, coreReset}, 16'h0000, "core released");
    endtask
    task automatic t_freeze();
        b = irqCount;
        @(negedge clk);
        clkEn = 1'b0;
        wr(hdx_pkg::ADDR_CTRL, 8'h03);
        settle();
        chk({15'h0000, coreReset}, 16'h0000, "frozen write ignored");
        chk(16'(irqCount - b), 16'h0000, "frozen no irq");
        clkEn = 1'b1;
        rdchk(hdx_pkg::ADDR_CTRL, 8'h00, "control unchanged after freeze");
    endtask
    task automatic t_data16();
        stat(16'habcd);
        rdchk(hdx_pkg::ADDR_STAT_A, 8'hab, "status first address");
        rdchk(hdx_pkg::ADDR_STAT_B, 8'hab, "status second address");
        b = rxCount;
        wr(hdx_pkg::ADDR_DATA_LO, 8'h34);
        settle();
        chk(16'(rxCount - b), 16'h0000, "low byte held");
        wr(hdx_pkg::ADDR_DATA_HI, 8'h12);
        settle();
        chk(16'(rxCount - b), 16'h0001, "word sent once");
        chk(i_core.rxLog[b % 16], 16'h1234, "word content");
        rdchk(hdx_pkg::ADDR_DATA_LO, 8'h34, "data low readback");
        rdchk(hdx_pkg::ADDR_DATA_HI, 8'h12, "data high readback");
    endtask
    task automatic t_byte_mode();
        stat(16'h0400);
        b = rxCount;
        wr(hdx_pkg::ADDR_DATA_LO, 8'h56);
        wr(hdx_pkg::ADDR_DATA_HI, 8'h99);
        settle();
        chk(16'(rxCount - b), 16'h0001, "byte mode one word");
        chk(i_core.rxLog[b % 16], 16'h1256, "high byte kept");
        rdchk(hdx_pkg::ADDR_DATA_HI, 8'h12, "high write ignored");
        stat(16'h0000);
        @(negedge clk);
        coreTxWr = 1'b1;
        coreTxData = 16'hbeef;
        @(negedge clk);
        coreTxWr = 1'b0;
        rdchk(hdx_pkg::ADDR_DATA_LO, 8'hef, "core word low");
        rdchk(hdx_pkg::ADDR_DATA_HI, 8'hbe, "core word high");
    endtask
    task automatic t_fifo_full();
        stall = 1'b1;
        b = rxCount;
        for (int i = 0; i < hdx_pkg::FIFO_DEPTH + 1; i++) begin
            wr(hdx_pkg::ADDR_DATA_LO, 8'(i));
            wr(hdx_pkg::ADDR_DATA_HI, 8'ha0);
        end
        settle();
        chk({15'h0000, hostWrBusy}, 16'h0001, "fifo full busy");
        stall = 1'b0;
        repeat (8) @(negedge clk);
        chk(16'(rxCount - b), 16'(hdx_pkg::FIFO_DEPTH), "extra word dropped");
        for (int i = 0; i < hdx_pkg::FIFO_DEPTH; i++) begin
            chk(i_core.rxLog[(b + i) % 16], 16'ha000 + 16'(i), "fifo order");
        end
        chk({15'h0000, hostWrBusy}, 16'h0000, "fifo drained");
    endtask
    task automatic t_mid_reset();
        stat(16'hff00);
        wr(hdx_pkg::ADDR_CTRL, 8'h01);
        settle();
        rst_n = 1'b0;
        @(negedge clk);
        rst_n = 1'b1;
        t_reset_vals();
    endtask
    task automatic complete_run();
        $display("comparisons %0d mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // ------------------------------------------------------------
    // Clock, reset, sequence and watchdog
    // ------------------------------------------------------------
    initial begin
        clk = 1'b0;
        forever #2 clk = ~clk;
    end
    initial begin
        {rst_n, hostWr, hostRd, statWr, coreTxWr, stall} = 6'h00;
        clkEn = 1'b1;
        {hostAddr, statWrData, coreTxData, hostWrData} = 56'h0;
        n_fail = 0;
        cmp_count = 0;
        repeat (5) @(negedge clk);
        rst_n = 1'b1;
        t_reset_vals();
        t_ctrl();
        t_freeze();
        t_data16();
        t_byte_mode();
        t_fifo_full();
        t_mid_reset();
        complete_run();
    end
    initial begin
        #40000;
        n_fail++;
        complete_run();
    end
endmodule
